// [hw/mic_irq_ctrl.sv]
// interrupt controller for an 8-bit core, with axi4-lite register access
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "mic_defines.svh"
module mic_irq_ctrl
  import mic_pkg::*;
#(
  parameter int SRC2_PINS = 4,
  parameter int SRC3_EVTS = 2,
  parameter int SRC4_EVTS = 1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read channels
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // request pins; nmi and source one active low, source two edge polarity selectable
  input wire logic nmi_pin_n,
  input wire logic src1_pin_n,
  input wire logic [SRC2_PINS-1:0] src2_pins,
  // peripheral level requests
  input wire logic [SRC3_EVTS-1:0] src3_req,
  input wire logic [SRC4_EVTS-1:0] src4_req,
  // core sequencing
  input wire logic instr_end,
  input wire logic return_from_irq,
  input wire logic opt_clr_start,
  input wire logic low_power,
  // core flags
  input wire logic flag_we,
  input wire logic carry_in,
  input wire logic zero_in,
  output logic carry_flag,
  output logic zero_flag,
  // entry and return to the core
  output logic irq_take,
  output logic [11:0] irq_vector,
  output logic stack_push,
  output logic stack_pop,
  output logic wake,
  output logic [1:0] core_mode
);

  // ========================================================
  // pin conditioning
  logic nmi_fall;
  logic s1_level;
  logic s1_fall;
  logic [SRC2_PINS-1:0] s2_level;
  logic [SRC2_PINS-1:0] s2_rise;
  logic [SRC2_PINS-1:0] s2_fall;
  logic [SRC2_PINS-1:0] s2_evt;
  logic [SRC2_PINS-1:0] evt_clr;
  logic [SRC2_PINS-1:0] evt_flags;

  mic_pin_sync u_nmi_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(nmi_pin_n),
    .level(),
    .rise(),
    .fall(nmi_fall)
  );

  mic_pin_sync u_s1_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(src1_pin_n),
    .level(s1_level),
    .rise(),
    .fall(s1_fall)
  );

  for (genvar i = 0; i < SRC2_PINS; i++) begin : g_s2
    mic_pin_sync u_s2_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(src2_pins[i]),
      .level(s2_level[i]),
      .rise(s2_rise[i]),
      .fall(s2_fall[i])
    );
  end

  // ========================================================
  // option register and its fields
  logic [7:0] opt;
  logic lvl_sel;
  logic pol_sel;
  logic ena;

  assign lvl_sel = opt[`MIC_OPT_LVL_BIT];
  assign pol_sel = opt[`MIC_OPT_POL_BIT];
  assign ena = opt[`MIC_OPT_ENA_BIT];

  // per-pin edge on the selected polarity, pins share one source
  assign s2_evt = pol_sel ? s2_rise : s2_fall;

  // each pin keeps its own flag for polling
  mic_event_flags #(
    .N(SRC2_PINS)
  ) u_s2_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(s2_evt),
    .clr(evt_clr),
    .flags(evt_flags)
  );

  // ========================================================
  // request state
  mic_mode_t mode;
  mic_mode_t nmi_ret_mode;
  mic_mode_t fsel;
  mic_mode_t nmi_ret_fsel;
  mic_mode_t irq_ret_fsel;
  logic nmi_latch;
  logic s1_latch;
  logic s2_latch;
  logic quirk;
  logic [2:0] clr_cnt;
  logic req1;
  logic req2;
  logic req3;
  logic req4;
  logic any_mreq;
  logic take_nmi;
  logic take_m;
  mic_src_t sel_src;
  logic [11:0] sel_vec;

  // level mode reads the pin low at sampling time only
  assign req1 = lvl_sel ? ~s1_level : s1_latch;
  assign req2 = s2_latch;
  assign req3 = |src3_req;
  assign req4 = |src4_req;
  assign any_mreq = req1 | req2 | req3 | req4;

  // nmi beats everything but a running nmi routine
  assign take_nmi = instr_end & ~return_from_irq & nmi_latch
    & (mode != MIC_MODE_NMI);
  // maskable only from normal mode; the quirk slips past a late clear
  assign take_m = instr_end & ~return_from_irq & ~take_nmi & any_mreq
    & (mode == MIC_MODE_NORMAL) & (ena | quirk);

  // fixed priority, nmi first, then source one
  always_comb begin
    if (take_nmi) begin
      sel_src = MIC_SRC_0;
      sel_vec = `MIC_VEC_SRC0;
    end else if (req1) begin
      sel_src = MIC_SRC_1;
      sel_vec = `MIC_VEC_SRC1;
    end else if (req2) begin
      sel_src = MIC_SRC_2;
      sel_vec = `MIC_VEC_SRC2;
    end else if (req3) begin
      sel_src = MIC_SRC_3;
      sel_vec = `MIC_VEC_SRC3;
    end else begin
      sel_src = MIC_SRC_4;
      sel_vec = `MIC_VEC_SRC4;
    end
  end

  // nmi flip-flop; a new edge in the clear cycle is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_latch <= 1'b0;
    end else if (nmi_fall) begin
      nmi_latch <= 1'b1;
    end else if (take_nmi) begin
      nmi_latch <= 1'b0;
    end
  end

  // source one edge latch, idle in level mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_latch <= 1'b0;
    end else if (lvl_sel) begin
      s1_latch <= 1'b0;
    end else if (s1_fall) begin
      s1_latch <= 1'b1;
    end else if (take_m && sel_src == MIC_SRC_1) begin
      s1_latch <= 1'b0;
    end
  end

  // source two edge latch; later edges merge into the held one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s2_latch <= 1'b0;
    end else if (|s2_evt) begin
      s2_latch <= 1'b1;
    end else if (take_m && sel_src == MIC_SRC_2) begin
      s2_latch <= 1'b0;
    end
  end

  // ========================================================
  // option-clear instruction window: its first cycles arm the quirk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clr_cnt <= 3'h0;
    end else if (opt_clr_start) begin
      clr_cnt <= 3'h1;
    end else if (clr_cnt != 3'h0 && clr_cnt < `MIC_CLR_INSTR_CYC - 3'h1) begin
      clr_cnt <= clr_cnt + 3'h1;
    end else begin
      clr_cnt <= 3'h0;
    end
  end

  // armed while enabled, consumed at the next boundary
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      quirk <= 1'b0;
    end else if ((opt_clr_start || (clr_cnt != 3'h0 && clr_cnt < `MIC_CLR_QUIRK_CYC))
                 && ena && any_mreq && mode == MIC_MODE_NORMAL) begin
      quirk <= 1'b1;
    end else if (instr_end) begin
      quirk <= 1'b0;
    end
  end

  // ========================================================
  // mode and flag-pair sequencing; reset starts in nmi mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= MIC_MODE_NMI;
      fsel <= MIC_MODE_NMI;
      nmi_ret_mode <= MIC_MODE_NORMAL;
      nmi_ret_fsel <= MIC_MODE_NORMAL;
      irq_ret_fsel <= MIC_MODE_NORMAL;
    end else if (take_nmi) begin
      nmi_ret_mode <= mode;
      nmi_ret_fsel <= fsel;
      mode <= MIC_MODE_NMI;
      fsel <= MIC_MODE_NMI;
    end else if (take_m) begin
      irq_ret_fsel <= fsel;
      mode <= MIC_MODE_IRQ;
      if (!ena) begin
        fsel <= fsel;
      end else begin
        fsel <= MIC_MODE_IRQ;
      end
    end else if (return_from_irq) begin
      unique case (mode)
        MIC_MODE_NMI: begin
          mode <= nmi_ret_mode;
          fsel <= nmi_ret_fsel;
        end
        MIC_MODE_IRQ: begin
          mode <= MIC_MODE_NORMAL;
          fsel <= irq_ret_fsel;
        end
        MIC_MODE_NORMAL: begin
          mode <= MIC_MODE_NORMAL;
        end
        default: begin
          mode <= MIC_MODE_NORMAL;
          fsel <= MIC_MODE_NORMAL;
        end
      endcase
    end
  end

  // ========================================================
  // three carry/zero pairs, indexed by the selected set
  logic [2:0] pair_c;
  logic [2:0] pair_z;

  // only the pair in use is written, the others keep their values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pair_c <= 3'h0;
      pair_z <= 3'h0;
    end else if (flag_we) begin
      pair_c[fsel] <= carry_in;
      pair_z[fsel] <= zero_in;
    end
  end

  // registered view of the active pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carry_flag <= 1'b0;
      zero_flag <= 1'b0;
      core_mode <= MIC_MODE_NMI;
    end else begin
      carry_flag <= pair_c[fsel];
      zero_flag <= pair_z[fsel];
      core_mode <= mode;
    end
  end

  // ========================================================
  // entry and return strobes to the core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_take <= 1'b0;
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      irq_vector <= 12'h000;
    end else begin
      irq_take <= take_nmi | take_m;
      stack_push <= take_nmi | take_m;
      stack_pop <= return_from_irq & (mode != MIC_MODE_NORMAL);
      if (take_nmi || take_m) begin
        irq_vector <= sel_vec;
      end
    end
  end

  // wake needs the global enable even for the nmi
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake <= 1'b0;
    end else begin
      wake <= low_power & ena & (nmi_latch | any_mreq);
    end
  end

  // ========================================================
  // axi4-lite write side; address and data taken in either order
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;

  assign do_write = aw_held & w_held & ~bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      awready <= 1'b0;
      aw_addr_q <= 12'h000;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      awready <= 1'b0;
      aw_addr_q <= awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else begin
      awready <= ~aw_held & ~awready;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      wready <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      wready <= 1'b0;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end else begin
      wready <= ~w_held & ~wready;
    end
  end

  // write-only option register; no single-bit access path exists
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opt <= `MIC_OPT_RESET;
    end else if (do_write && aw_addr_q == `MIC_OPT_ADDR && w_strb_q[0]) begin
      opt <= w_data_q[7:0];
    end
  end

  // write one to clear a pin flag
  assign evt_clr = (do_write && aw_addr_q == `MIC_EVT_ADDR && w_strb_q[0])
    ? w_data_q[SRC2_PINS-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `MIC_RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= (aw_addr_q == `MIC_OPT_ADDR || aw_addr_q == `MIC_EVT_ADDR)
        ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ========================================================
  // axi4-lite read side; option register reads back zero
  logic [31:0] stat_word;

  assign stat_word = {16'h0000, 1'b0, sel_src, req4, req3, req2, req1,
    s2_latch, s1_latch, nmi_latch, quirk, fsel, mode};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `MIC_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= `MIC_RESP_OKAY;
      if (araddr == `MIC_STAT_ADDR) begin
        rdata <= stat_word;
      end else if (araddr == `MIC_EVT_ADDR) begin
        rdata <= 32'(evt_flags);
      end else if (araddr == `MIC_OPT_ADDR) begin
        rdata <= 32'h0000_0000;
      end else begin
        rdata <= 32'h0000_0000;
        rresp <= `MIC_RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else begin
      arready <= ~rvalid & ~arready;
    end
  end

endmodule // mic_irq_ctrl

// [hw/mic_defines.svh]
// offsets, field positions, reset values and timing counts of the interrupt controller
`ifndef MIC_DEFINES_SVH
`define MIC_DEFINES_SVH

// ==========================================================
// register map (option register sits at data index C8h)
`define MIC_OPT_IDX 12'h0C8
`define MIC_OPT_ADDR 12'h320
`define MIC_STAT_ADDR 12'h324
`define MIC_EVT_ADDR 12'h328
`define MIC_OPT_RESET 8'h00

// ==========================================================
// option register fields
`define MIC_OPT_LVL_BIT 6
`define MIC_OPT_POL_BIT 5
`define MIC_OPT_ENA_BIT 4

// ==========================================================
// fixed vector addresses (low byte of each pair)
`define MIC_VEC_SRC0 12'hFFC
`define MIC_VEC_SRC1 12'hFF6
`define MIC_VEC_SRC2 12'hFF4
`define MIC_VEC_SRC3 12'hFF2
`define MIC_VEC_SRC4 12'hFF0

// ==========================================================
// option-clear instruction timing, in core cycles
`define MIC_CLR_INSTR_CYC 3'h4
`define MIC_CLR_QUIRK_CYC 3'h3

// ==========================================================
// axi response codes
`define MIC_RESP_OKAY 2'h0
`define MIC_RESP_SLVERR 2'h2

`endif

// [hw/mic_pkg.sv]
// types shared by the interrupt controller modules
package mic_pkg;

  // operating mode of the core, also selects the flag pair
  typedef enum logic [1:0] {
    MIC_MODE_NORMAL = 2'b00,
    MIC_MODE_IRQ = 2'b01,
    MIC_MODE_NMI = 2'b10
  } mic_mode_t;

  // interrupt source number
  typedef enum logic [2:0] {
    MIC_SRC_0 = 3'b000,
    MIC_SRC_1 = 3'b001,
    MIC_SRC_2 = 3'b010,
    MIC_SRC_3 = 3'b011,
    MIC_SRC_4 = 3'b100
  } mic_src_t;

endpackage

// [hw/mic_pin_sync.sv]
// two-stage synchroniser with edge detection for one request pin
`timescale 1ns/1ps
module mic_pin_sync (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // raw pin and conditioned results
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta;
  logic stable;
  logic prev;

  // ========================================================
  // first stage is read only by the second; reset loads the pin level
  // into every stage, since a pin may idle low and a fixed reset value
  // would show a false edge once reset lets go
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= pin;
      stable <= pin;
      prev <= pin;
    end else begin
      meta <= pin;
      stable <= meta;
      prev <= stable;
    end
  end

  // edges seen on settled values only
  assign level = stable;
  assign rise = stable & ~prev;
  assign fall = ~stable & prev;

endmodule // mic_pin_sync

// [hw/mic_event_flags.sv]
// sticky per-event flags, set by hardware, cleared by software
`timescale 1ns/1ps
module mic_event_flags #(
  parameter int N = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // events and clears
  input wire logic [N-1:0] set,
  input wire logic [N-1:0] clr,
  output logic [N-1:0] flags
);

  // ========================================================
  // a set in the clear cycle survives so no event is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~clr) | set;
    end
  end

endmodule // mic_event_flags

// [tb/mic_irq_ctrl_props.sv]
// concurrent checks on the core link of the interrupt controller
`timescale 1ns/1ps
module mic_irq_ctrl_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // core sequencing
  input wire logic instr_end,
  input wire logic return_from_irq,
  // entry and return
  input wire logic irq_take,
  input wire logic [11:0] irq_vector,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic [1:0] core_mode
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // return steps: return in a routine, then a pop
  sequence s_ret;
    return_from_irq && core_mode != 2'h0;
  endsequence
  sequence s_pop;
    ##1 stack_pop;
  endsequence
  property p_pop;
    s_ret |-> s_pop;
  endproperty
  a_pop: assert property (p_pop) else $error("return without pop");
  property p_pop_cause;
    stack_pop |-> $past(return_from_irq) && $past(core_mode) != 2'h0;
  endproperty
  a_pop_cause: assert property (p_pop_cause) else $error("pop without return");
  // ==========================================
  // entry steps
  property p_take_cause;
    irq_take |-> $past(instr_end) && !$past(return_from_irq);
  endproperty
  a_take_cause: assert property (p_take_cause) else $error("entry off boundary");
  property p_push;
    stack_push == irq_take;
  endproperty
  a_push: assert property (p_push) else $error("push not with entry");
  property p_nmi_mode;
    irq_take && irq_vector == 12'hFFC |=> core_mode == 2'h2;
  endproperty
  a_nmi_mode: assert property (p_nmi_mode) else $error("nmi entry mode wrong");
  property p_mask_mode;
    irq_take && irq_vector != 12'hFFC |=> core_mode == 2'h1;
  endproperty
  a_mask_mode: assert property (p_mask_mode) else $error("maskable entry mode wrong");
  property p_no_preempt;
    irq_take && $past(core_mode) == 2'h1 |-> irq_vector == 12'hFFC;
  endproperty
  a_no_preempt: assert property (p_no_preempt) else $error("maskable preempted");
  property p_nmi_busy;
    irq_take |-> $past(core_mode) != 2'h2;
  endproperty
  a_nmi_busy: assert property (p_nmi_busy) else $error("entry inside nmi routine");
  property p_vec_set;
    irq_take |-> irq_vector inside {12'hFFC, 12'hFF6, 12'hFF4, 12'hFF2, 12'hFF0};
  endproperty
  a_vec_set: assert property (p_vec_set) else $error("vector not a fixed one");
  property p_vec_hold;
    !irq_take |-> $stable(irq_vector);
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
endmodule // mic_irq_ctrl_chk

bind mic_irq_ctrl mic_irq_ctrl_chk chk_u (
  .aclk, .aresetn, .instr_end, .return_from_irq, .irq_take, .irq_vector,
  .stack_push, .stack_pop, .core_mode
);

// [tb/mic_core_model.sv]
// behavioural core: paces instruction boundaries and executes returns
`timescale 1ns/1ps
module mic_core_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pacing and return command from the bench
  input wire logic [3:0] gap,
  input wire logic ret_req,
  // boundary strobes to the controller
  output logic instr_end,
  output logic return_from_irq
);
  logic [3:0] cnt;
  // a boundary every gap+1 cycles; a large gap plays a slow core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 4'h0;
      instr_end <= 1'b0;
      return_from_irq <= 1'b0;
    end else begin
      cnt <= (cnt >= gap) ? 4'h0 : cnt + 4'h1;
      instr_end <= (cnt >= gap);
      return_from_irq <= (cnt >= gap) && ret_req;
    end
  end
endmodule // mic_core_model

// [tb/mic_irq_ctrl_bench.sv]
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "mic_defines.svh"
module mic_irq_ctrl_bench;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0, irq_vector;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0] wstrb = 0, src2_pins = 0, gap = 4'h3;
  logic [1:0] bresp, rresp, core_mode, rs, src3_req = 0;
  logic [0:0] src4_req = 0;
  logic nmi_pin_n = 1, src1_pin_n = 1, opt_clr_start = 0, low_power = 0, ret_req = 0;
  logic flag_we = 0, carry_in = 0, zero_in = 0, awready, wready, bvalid, arready, rvalid;
  logic instr_end, return_from_irq, carry_flag, zero_flag, irq_take, stack_push, stack_pop, wake;
  int miscompares = 0, checks_done = 0, takes = 0, done_takes = 0;
  // ==========================================
  // clock, design, core model
  always #2 aclk = ~aclk;
  mic_irq_ctrl dut_u (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .nmi_pin_n, .src1_pin_n, .src2_pins, .src3_req, .src4_req, .instr_end,
    .return_from_irq, .opt_clr_start, .low_power, .flag_we, .carry_in, .zero_in,
    .carry_flag, .zero_flag, .irq_take, .irq_vector, .stack_push, .stack_pop, .wake,
    .core_mode
  );
  mic_core_model core_u (.aclk, .aresetn, .gap, .ret_req, .instr_end, .return_from_irq);
  // entries seen so far, for checks that nothing was taken
  always @(posedge aclk) if (irq_take === 1'b1) takes <= takes + 1;
  // ==========================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic opt(input logic [7:0] v);
    axi_wr(`MIC_OPT_ADDR, {24'h0, v});
    chk("opt bresp", `MIC_RESP_OKAY, rs);
  endtask
  task automatic expect_take(input logic [11:0] v, input logic [1:0] m);
    int n;
    n = 0;
    // counted entries, so one taken before the call is not missed
    while (takes == done_takes && n < 80) begin
      @(posedge aclk);
      n++;
    end
    // core_mode follows the entry one cycle after the vector
    @(posedge aclk);
    chk("irq_take count", done_takes + 1, takes);
    done_takes = takes;
    chk("irq_vector", v, irq_vector);
    chk("core_mode", m, core_mode);
  endtask
  task automatic do_ret(input logic [1:0] m);
    @(posedge aclk);
    ret_req <= 1'b1;
    do @(posedge aclk); while (return_from_irq !== 1'b1);
    ret_req <= 1'b0;
    @(posedge aclk);
    chk("stack_pop", 1, stack_pop);
    @(posedge aclk);
    chk("mode after return", m, core_mode);
  endtask
  task automatic no_take(input int n);
    int t;
    t = takes;
    repeat (n) @(posedge aclk);
    chk("entries", t, takes);
  endtask
  task automatic pulse_src1();
    src1_pin_n <= 1'b0;
    repeat (4) @(posedge aclk);
    src1_pin_n <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask
  function automatic logic [11:0] exp_vec(input logic [2:0] r);
    return (|r[1:0]) ? `MIC_VEC_SRC3 : `MIC_VEC_SRC4;
  endfunction
  // ==========================================
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    print_verdict();
  end
  // ==========================================
  // main sequence
  initial begin
    rd = $urandom(2);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_rd(`MIC_OPT_ADDR);
    chk("option reads zero", 0, rd);
    axi_rd(12'h3FC);
    chk("unmapped resp", `MIC_RESP_SLVERR, rs);
    do_ret(2'h0);
    flag_we <= 1'b1;
    carry_in <= 1'b1;
    zero_in <= 1'b1;
    @(posedge aclk);
    flag_we <= 1'b0;
    $display("test registers done");
    // priority, level sources, flag pairs, nmi preemption
    opt(8'h10);
    src3_req <= 2'b10;
    src4_req <= 1'b1;
    expect_take(`MIC_VEC_SRC3, 2'h1);
    @(posedge aclk);
    chk("irq pair carry", 0, carry_flag);
    nmi_pin_n <= 1'b0;
    expect_take(`MIC_VEC_SRC0, 2'h2);
    nmi_pin_n <= 1'b1;
    do_ret(2'h1);
    src3_req <= 2'b00;
    do_ret(2'h0);
    @(posedge aclk);
    chk("normal pair carry", 1, carry_flag);
    chk("normal pair zero", 1, zero_flag);
    expect_take(`MIC_VEC_SRC4, 2'h1);
    // edges of source one during a routine: only one is kept
    src4_req <= 1'b0;
    pulse_src1();
    pulse_src1();
    do_ret(2'h0);
    expect_take(`MIC_VEC_SRC1, 2'h1);
    do_ret(2'h0);
    no_take(30);
    $display("test priority done");
    // level mode source one beats source three; short pulses are lost
    opt(8'h50);
    src4_req <= 1'b1;
    expect_take(`MIC_VEC_SRC4, 2'h1);
    src4_req <= 1'b0;
    src1_pin_n <= 1'b0;
    src3_req <= 2'b01;
    do_ret(2'h0);
    expect_take(`MIC_VEC_SRC1, 2'h1);
    src1_pin_n <= 1'b1;
    do_ret(2'h0);
    expect_take(`MIC_VEC_SRC3, 2'h1);
    pulse_src1();
    src3_req <= 2'b00;
    do_ret(2'h0);
    no_take(30);
    $display("test level done");
    // source two, both polarities, with its event flag
    opt(8'h30);
    src2_pins <= 4'h4;
    expect_take(`MIC_VEC_SRC2, 2'h1);
    axi_rd(`MIC_EVT_ADDR);
    chk("pin flag", 4'h4, rd[3:0]);
    do_ret(2'h0);
    opt(8'h10);
    src2_pins <= 4'h0;
    expect_take(`MIC_VEC_SRC2, 2'h1);
    do_ret(2'h0);
    axi_wr(`MIC_EVT_ADDR, 32'h0000_0004);
    chk("evt bresp", `MIC_RESP_OKAY, rs);
    axi_rd(`MIC_EVT_ADDR);
    chk("pin flag cleared", 32'h0000_0000, rd);
    $display("test edges done");
    // global enable: blocks maskable, not nmi; gates wake-up; slow core
    opt(8'h00);
    src4_req <= 1'b1;
    no_take(40);
    gap <= 4'hF;
    low_power <= 1'b1;
    nmi_pin_n <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("wake while disabled", 0, wake);
    expect_take(`MIC_VEC_SRC0, 2'h2);
    nmi_pin_n <= 1'b1;
    do_ret(2'h0);
    opt(8'h10);
    @(posedge aclk);
    chk("wake while enabled", 1, wake);
    expect_take(`MIC_VEC_SRC4, 2'h1);
    src4_req <= 1'b0;
    low_power <= 1'b0;
    do_ret(2'h0);
    // request early in the option-clear instruction: entry without swap
    do @(posedge aclk); while (instr_end !== 1'b1);
    src4_req <= 1'b1;
    opt_clr_start <= 1'b1;
    @(posedge aclk);
    opt_clr_start <= 1'b0;
    opt(8'h00);
    expect_take(`MIC_VEC_SRC4, 2'h1);
    @(posedge aclk);
    chk("quirk keeps pair", 1, carry_flag);
    src4_req <= 1'b0;
    do_ret(2'h0);
    $display("test enable done");
    // random level mixes of sources three and four at random core pace
    opt(8'h10);
    repeat (8) begin
      rd = $urandom;
      gap <= 4'h2 + {2'h0, rd[5:4]};
      src3_req <= rd[1:0];
      src4_req <= rd[2];
      if (rd[2:0] != 3'h0) begin
        expect_take(exp_vec(rd[2:0]), 2'h1);
        src3_req <= 2'b00;
        src4_req <= 1'b0;
        do_ret(2'h0);
      end else begin
        no_take(20);
      end
    end
    $display("test random done");
    print_verdict();
  end
endmodule // mic_irq_ctrl_bench
